// file: hw/vis_top.sv
`timescale 1ns/1ps
`include "vis_map.svh"
module vis_top #(
  parameter int CAPCOMP_N = `VIS_CCF_N
) (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic                   ce,
  input  wire logic                   ext0_pending,
  input  wire logic                   timer0_overflow_flag,
  input  wire logic                   ext1_pending,
  input  wire logic                   timer1_overflow_flag,
  input  wire logic                   serial0_receive_flag,
  input  wire logic                   serial0_transmit_flag,
  input  wire logic                   timer2_high_overflow,
  input  wire logic                   timer2_low_overflow,
  input  wire logic                   spi_transfer_done,
  input  wire logic                   spi_write_collision,
  input  wire logic                   spi_mode_fault,
  input  wire logic                   spi_receive_overrun,
  input  wire logic                   twowire_unit_a_flag,
  input  wire logic                   conv_window_flag,
  input  wire logic                   conv_done_flag,
  input  wire logic                   counter_array_overflow,
  input  wire logic [CAPCOMP_N-1:0]   capcomp_module_flag,
  input  wire logic                   cmp0_falling_flag,
  input  wire logic                   cmp0_rising_flag,
  input  wire logic                   cmp1_falling_flag,
  input  wire logic                   cmp1_rising_flag,
  input  wire logic                   timer3_high_overflow,
  input  wire logic                   timer3_low_overflow,
  input  wire logic                   ext_input_two_level,
  input  wire logic                   serial1_receive_flag,
  input  wire logic                   serial1_transmit_flag,
  input  wire logic                   twowire_unit_b_flag,
  input  wire logic                   timer4_high_overflow,
  input  wire logic                   timer4_low_overflow,
  input  wire logic                   timer5_high_overflow,
  input  wire logic                   timer5_low_overflow,
  input  wire logic [7:0]             int_enable_reg,
  input  wire logic [7:0]             ext_enable_reg_a,
  input  wire logic [7:0]             ext_enable_reg_b,
  input  wire logic [6:0]             int_priority_reg,
  input  wire logic [7:0]             ext_priority_reg_a,
  input  wire logic [7:0]             ext_priority_reg_b,
  input  wire logic                   irq_ack,
  input  wire logic                   irq_reti,
  output      logic                   irq_request,
  output      vis_pkg::vis_vec_t      irq_vector,
  output      logic [`VIS_HWCLR_N-1:0] hw_flag_clear,
  output      logic [1:0]             service_level
);

  if (CAPCOMP_N < 1 || CAPCOMP_N > `VIS_CCF_MAX) begin : g_chk
    $error("CAPCOMP_N out of range");
  end

  localparam vis_pkg::vis_state_t VIS_RST_S = '{
    phase:    vis_pkg::VIS_BOOT,
    ext_input_two_level_meta: 1'b0,
    ext_input_two_level_sync: 1'b0,
    irq_req:  1'b1,
    vec:      `VIS_RESET_VEC,
    win_rank: '0,
    win_hi:   1'b0,
    svc_low:  1'b0,
    svc_high: 1'b0,
    hw_clear: '0
  };

  vis_pkg::vis_state_t s;
  vis_pkg::vis_state_t next_s;

  vis_pkg::vis_slots_t raw;
  vis_pkg::vis_slots_t en;
  vis_pkg::vis_slots_t pri;
  vis_pkg::vis_slots_t masked;
  logic                global_on;
  logic                take;
  logic                eligible;

  vis_if arb ();

  vis_rank u_rank (
    .bus (arb.rank)
  );

  // Flags come from peripheral logic on this clock; only the level
  // input two is a pin and goes through the synchroniser in s.
  assign raw[0]  = ext0_pending;
  assign raw[1]  = timer0_overflow_flag;
  assign raw[2]  = ext1_pending;
  assign raw[3]  = timer1_overflow_flag;
  assign raw[4]  = serial0_receive_flag | serial0_transmit_flag;
  assign raw[5]  = timer2_high_overflow | timer2_low_overflow;
  assign raw[6]  = spi_transfer_done | spi_write_collision
                 | spi_mode_fault | spi_receive_overrun;
  assign raw[7]  = twowire_unit_a_flag;
  assign raw[`VIS_RSV_A] = 1'b0;
  assign raw[9]  = conv_window_flag;
  assign raw[10] = conv_done_flag;
  assign raw[11] = counter_array_overflow
                 | (|capcomp_module_flag);
  assign raw[12] = cmp0_falling_flag | cmp0_rising_flag;
  assign raw[13] = cmp1_falling_flag | cmp1_rising_flag;
  assign raw[14] = timer3_high_overflow | timer3_low_overflow;
  assign raw[15] = s.ext_input_two_level_sync;
  assign raw[16] = serial1_receive_flag | serial1_transmit_flag;
  assign raw[`VIS_RSV_B] = 1'b0;
  assign raw[18] = twowire_unit_b_flag;
  assign raw[19] = timer4_high_overflow | timer4_low_overflow;
  assign raw[20] = timer5_high_overflow | timer5_low_overflow;

  // Slot n maps onto enable and priority bit n of the register chain
  // int[6:0], ext_a[7:0], ext_b[5:0]; the reserved slots have raw
  // tied low, so their register bits steer nothing.
  assign en  = {ext_enable_reg_b[5:0], ext_enable_reg_a,
                int_enable_reg[6:0]};
  assign pri = {ext_priority_reg_b[5:0], ext_priority_reg_a,
                int_priority_reg};

  assign global_on = int_enable_reg[`VIS_GLOBAL_BIT];
  assign masked    = raw & en & {`VIS_NSLOT{global_on}};

  assign arb.req = masked;
  assign arb.hi  = pri;

  assign take = s.irq_req & irq_ack;

  // Nothing beats an active high routine; a low routine only yields
  // to a high-level winner.
  assign eligible = arb.win_valid & ~s.svc_high
                  & (~s.svc_low | arb.win_hi);

  always_comb begin
    next_s           = s;
    next_s.hw_clear  = '0;
    next_s.ext_input_two_level_meta = ext_input_two_level;
    next_s.ext_input_two_level_sync = s.ext_input_two_level_meta;
    unique case (s.phase)
      vis_pkg::VIS_BOOT: begin
        // Reset request stands until the core takes it; others wait
        if (irq_ack) begin
          next_s.phase   = vis_pkg::VIS_RUN;
          next_s.irq_req = 1'b0;
        end
      end
      vis_pkg::VIS_RUN: begin
        if (irq_reti) begin
          if (s.svc_high) begin
            next_s.svc_high = 1'b0;
          end else begin
            next_s.svc_low = 1'b0;
          end
        end
        if (take) begin
          if (s.win_hi) begin
            next_s.svc_high = 1'b1;
          end else begin
            next_s.svc_low = 1'b1;
          end
          // Only the four lowest ranks are cleared by hardware
          if (s.win_rank < `VIS_HWCLR_N) begin
            next_s.hw_clear[s.win_rank[1:0]] = 1'b1;
          end
        end
        // Decoded fresh every cycle: one cycle from flag to strobe, three for the synchronised level input two
        next_s.irq_req = eligible & ~take;
        if (eligible) begin
          next_s.win_rank = arb.win_rank;
          next_s.win_hi   = arb.win_hi;
          next_s.vec      = vis_pkg::vis_vec_of(arb.win_rank);
        end
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= VIS_RST_S;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign irq_request   = s.irq_req;
  assign irq_vector    = s.vec;
  assign hw_flag_clear = s.hw_clear;
  assign service_level = {s.svc_high, s.svc_low};

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  localparam vis_pkg::vis_rank_t VIS_RK_A = vis_pkg::vis_rank_t'(`VIS_RSV_A);
  localparam vis_pkg::vis_rank_t VIS_RK_B = vis_pkg::vis_rank_t'(`VIS_RSV_B);

  logic run;
  assign run = (s.phase == vis_pkg::VIS_RUN);

  a_boot_vector: assert property (
    !run |-> irq_request && irq_vector == `VIS_RESET_VEC
  ) else $error("reset request missing or wrong vector");

  a_boot_first: assert property (
    $rose(run) |-> $past(irq_ack) && !irq_request
  ) else $error("left reset request without ack");

  a_global_mask: assert property (
    ce && run && !global_on |=> !irq_request
  ) else $error("request while globally disabled");

  a_ext0_detect: assert property (
    ce && run && !s.svc_low && !s.svc_high && !irq_request
    && global_on && int_enable_reg[0] && int_priority_reg[0]
    && ext0_pending
    |=> irq_request && irq_vector == `VIS_VEC_BASE
  ) else $error("high ext input zero not vectored in one cycle");

  a_reserved_slot: assert property (
    run && irq_request
    |-> irq_vector != vis_pkg::vis_vec_of(VIS_RK_A)
        && irq_vector != vis_pkg::vis_vec_of(VIS_RK_B)
  ) else $error("reserved vector requested");

  a_high_blocks: assert property (
    s.svc_high |-> !irq_request
  ) else $error("request during high level routine");

  a_low_preempt: assert property (
    run && s.svc_low && irq_request |-> s.win_hi
  ) else $error("low request during low level routine");

  a_hw_clear: assert property (
    ce && run && take && irq_vector == `VIS_VEC_BASE
    |=> hw_flag_clear == 4'h1
  ) else $error("ext input zero flag not cleared on ack");

  a_soft_clear: assert property (
    ce && run && take && s.win_rank >= `VIS_HWCLR_N
    |=> hw_flag_clear == 4'h0
  ) else $error("software-cleared flag cleared by hardware");

  a_ack_level: assert property (
    ce && run && take && !irq_reti
    |=> ($past(s.win_hi) ? s.svc_high : s.svc_low) && !irq_request
  ) else $error("service level not set on ack");

  a_reti_restore: assert property (
    ce && run && irq_reti && s.svc_high && !take
    |=> !s.svc_high && s.svc_low == $past(s.svc_low)
  ) else $error("return did not restore previous level");

  // A frozen block must look frozen from outside as well
  a_ce_freeze: assert property (
    !ce |=> $stable(irq_request) && $stable(irq_vector)
            && $stable(service_level) && $stable(hw_flag_clear)
  ) else $error("state moved while clock enable low");

  a_boot_stay: assert property (
    ce && !run && !irq_ack |=> !run
  ) else $error("left reset request without ack");

  a_clear_onehot: assert property (
    $onehot0(hw_flag_clear)
  ) else $error("more than one flag cleared at once");

  a_clear_pulse: assert property (
    ce && (hw_flag_clear != 4'h0) |=> hw_flag_clear == 4'h0
  ) else $error("flag clear longer than one cycle");

  a_take_drop: assert property (
    ce && run && take |=> !irq_request
  ) else $error("request still high after ack");

  // Every vector lies on the slot grid between the first and last slot
  a_vec_range: assert property (
    run && irq_request
    |-> irq_vector >= `VIS_VEC_BASE
        && irq_vector <= vis_pkg::vis_vec_of(
             vis_pkg::vis_rank_t'(`VIS_NSLOT - 1))
        && irq_vector[2:0] == 3'h3
  ) else $error("vector off the slot grid");

  a_idle_quiet: assert property (
    ce && run && masked == '0 |=> !irq_request
  ) else $error("request with no enabled flag");

  a_hi_wins: assert property (
    ce && run && !s.svc_high && !s.svc_low && !take
    && ((masked & pri) != '0)
    |=> irq_request && s.win_hi
  ) else $error("high level request lost arbitration");

  // Rank zero at low level beats every other low request
  a_lo_pick: assert property (
    ce && run && !s.svc_high && !s.svc_low && !take
    && masked[0] && ((masked & pri) == '0)
    |=> irq_request && irq_vector == `VIS_VEC_BASE
  ) else $error("lowest rank did not win");

  a_reti_low: assert property (
    ce && run && irq_reti && !s.svc_high && s.svc_low && !take
    |=> !s.svc_low
  ) else $error("return did not end low level routine");

  a_level_hold: assert property (
    ce && run && !take && !irq_reti |=> $stable(service_level)
  ) else $error("service level moved without ack or return");

  a_rose_high: assert property (
    $rose(s.svc_high) |-> $past(take) && $past(s.win_hi)
  ) else $error("high level entered without high ack");

  a_rose_low: assert property (
    $rose(s.svc_low) |-> $past(take) && !$past(s.win_hi)
  ) else $error("low level entered without low ack");

  c_boot_ack: cover property (!run ##1 run);
  c_ce_hold: cover property (!ce && irq_request);
  c_preempt: cover property (s.svc_low ##1 s.svc_high);
  c_reti_req: cover property (
    run && irq_reti && s.svc_low ##1 !s.svc_low ##[1:4] irq_request);
  c_timer5: cover property (
    take && s.win_rank == vis_pkg::vis_rank_t'(20));

endmodule

// file: hw/vis_map.svh
`ifndef VIS_MAP_SVH
`define VIS_MAP_SVH

`define VIS_NSLOT      21
`define VIS_RANK_W     5
`define VIS_VEC_W      16
`define VIS_RESET_VEC  16'h0000
`define VIS_VEC_BASE   16'h0003
`define VIS_VEC_STEP   16'h0008
`define VIS_RSV_A      8
`define VIS_RSV_B      17
`define VIS_HWCLR_N    4
`define VIS_GLOBAL_BIT 7
`define VIS_CCF_N      5
`define VIS_CCF_MAX    8

`endif

// file: hw/vis_pkg.sv
`include "vis_map.svh"
package vis_pkg;

  typedef logic [`VIS_RANK_W-1:0] vis_rank_t;
  typedef logic [`VIS_VEC_W-1:0]  vis_vec_t;
  typedef logic [`VIS_NSLOT-1:0]  vis_slots_t;

  typedef enum logic {VIS_BOOT, VIS_RUN} vis_phase_t;

  typedef struct packed {
    vis_phase_t                phase;
    logic                      ext_input_two_level_meta;
    logic                      ext_input_two_level_sync;
    logic                      irq_req;
    vis_vec_t                  vec;
    vis_rank_t                 win_rank;
    logic                      win_hi;
    logic                      svc_low;
    logic                      svc_high;
    logic [`VIS_HWCLR_N-1:0]   hw_clear;
  } vis_state_t;

  function automatic vis_vec_t vis_vec_of(input vis_rank_t r);
    return `VIS_VEC_BASE + vis_vec_t'(r) * `VIS_VEC_STEP;
  endfunction

endpackage

// file: hw/vis_if.sv
`timescale 1ns/1ps
`include "vis_map.svh"
interface vis_if;
  vis_pkg::vis_slots_t req;
  vis_pkg::vis_slots_t hi;
  vis_pkg::vis_rank_t  win_rank;
  logic                win_valid;
  logic                win_hi;

  modport ask  (output req, hi, input win_rank, win_valid, win_hi);
  modport rank (input req, hi, output win_rank, win_valid, win_hi);
endinterface

// file: hw/vis_rank.sv
`timescale 1ns/1ps
`include "vis_map.svh"
module vis_rank (
  vis_if.rank bus
);

  // Lowest set slot; bit rank_w is the found flag
  function automatic logic [`VIS_RANK_W:0] vis_lowest(
    input vis_pkg::vis_slots_t v);
    logic [`VIS_RANK_W:0] res;
    res = '0;
    for (int i = `VIS_NSLOT - 1; i >= 0; i--) begin
      if (v[i]) begin
        res = {1'b1, vis_pkg::vis_rank_t'(i)};
      end
    end
    return res;
  endfunction

  logic [`VIS_RANK_W:0] hi_pick;
  logic [`VIS_RANK_W:0] lo_pick;

  always_comb begin
    hi_pick = vis_lowest(bus.req & bus.hi);
    lo_pick = vis_lowest(bus.req & ~bus.hi);
    // High level first, fixed rank inside a level
    if (hi_pick[`VIS_RANK_W]) begin
      bus.win_valid = 1'b1;
      bus.win_hi    = 1'b1;
      bus.win_rank  = hi_pick[`VIS_RANK_W-1:0];
    end else begin
      bus.win_valid = lo_pick[`VIS_RANK_W];
      bus.win_hi    = 1'b0;
      bus.win_rank  = lo_pick[`VIS_RANK_W-1:0];
    end
  end

endmodule

// file: verification/vis_core_model.sv
`timescale 1ns/1ps
module vis_core_model (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              irq_request,
  input  wire vis_pkg::vis_vec_t irq_vector,
  input  wire logic              auto_ack,
  input  wire logic [1:0]        lag,
  input  wire logic              reti_go,
  output      logic              irq_ack,
  output      logic              irq_reti,
  output      vis_pkg::vis_vec_t taken_vec,
  output      int                taken_cnt
);
  logic [1:0] cnt;

  // Ack only a standing request; lag lets the core answer slowly
  always @(negedge clk or posedge rst) begin
    if (rst) begin
      irq_ack  <= 1'b0;
      irq_reti <= 1'b0;
      cnt      <= 2'h0;
    end else begin
      irq_reti <= reti_go;
      if (irq_request && auto_ack && !irq_ack) begin
        if (cnt >= lag) begin
          irq_ack <= 1'b1;
          cnt     <= 2'h0;
        end else begin
          cnt <= cnt + 2'h1;
        end
      end else begin
        irq_ack <= 1'b0;
      end
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      taken_vec <= '0;
      taken_cnt <= 0;
    end else if (irq_ack && irq_request) begin
      taken_vec <= irq_vector;
      taken_cnt <= taken_cnt + 1;
    end
  end
endmodule

// file: verification/vis_top_tb_top.sv
`timescale 1ns/1ps
module vis_top_tb_top;
  logic              clk = 1'b0;
  logic              rst = 1'b1;
  logic              ce = 1'b1;
  logic              auto_ack = 1'b0;
  logic              reti_go = 1'b0;
  logic [1:0]        lag = 2'h0;
  logic [34:0]       f = '0;
  logic [7:0]        ien = 8'hFF;
  logic [6:0]        ip = 7'h7F;
  logic [7:0]        pb = 8'h00;
  logic              irq_ack;
  logic              irq_reti;
  logic              irq_request;
  vis_pkg::vis_vec_t irq_vector;
  vis_pkg::vis_vec_t taken_vec;
  logic [3:0]        hw_flag_clear;
  logic [1:0]        service_level;
  int                taken_cnt;
  int                n0;
  int                num_errors = 0;
  int                num_checks = 0;
  // Rank of each flag bit of f
  byte rk[35] = '{0, 1, 2, 3, 4, 4, 5, 5, 6, 6, 6, 6, 7, 9, 10,
                  11, 11, 11, 11, 11, 11, 12, 12, 13, 13, 14, 14,
                  15, 16, 16, 18, 19, 19, 20, 20};

  always #12.5 clk = ~clk;

  vis_top #(.CAPCOMP_N(5)) i_vis_top (
    .clk(clk), .rst(rst), .ce(ce),
    .ext0_pending(f[0]), .timer0_overflow_flag(f[1]),
    .ext1_pending(f[2]), .timer1_overflow_flag(f[3]),
    .serial0_receive_flag(f[4]), .serial0_transmit_flag(f[5]),
    .timer2_high_overflow(f[6]), .timer2_low_overflow(f[7]),
    .spi_transfer_done(f[8]), .spi_write_collision(f[9]),
    .spi_mode_fault(f[10]), .spi_receive_overrun(f[11]),
    .twowire_unit_a_flag(f[12]), .conv_window_flag(f[13]),
    .conv_done_flag(f[14]), .counter_array_overflow(f[15]),
    .capcomp_module_flag(f[20:16]),
    .cmp0_falling_flag(f[21]), .cmp0_rising_flag(f[22]),
    .cmp1_falling_flag(f[23]), .cmp1_rising_flag(f[24]),
    .timer3_high_overflow(f[25]), .timer3_low_overflow(f[26]),
    .ext_input_two_level(f[27]),
    .serial1_receive_flag(f[28]), .serial1_transmit_flag(f[29]),
    .twowire_unit_b_flag(f[30]),
    .timer4_high_overflow(f[31]), .timer4_low_overflow(f[32]),
    .timer5_high_overflow(f[33]), .timer5_low_overflow(f[34]),
    .int_enable_reg(ien), .ext_enable_reg_a(8'hFF),
    .ext_enable_reg_b(8'h3F), .int_priority_reg(ip),
    .ext_priority_reg_a(8'h00), .ext_priority_reg_b(pb),
    .irq_ack(irq_ack), .irq_reti(irq_reti),
    .irq_request(irq_request), .irq_vector(irq_vector),
    .hw_flag_clear(hw_flag_clear), .service_level(service_level)
  );

  vis_core_model i_vis_core_model (
    .clk(clk), .rst(rst), .irq_request(irq_request),
    .irq_vector(irq_vector), .auto_ack(auto_ack), .lag(lag),
    .reti_go(reti_go), .irq_ack(irq_ack), .irq_reti(irq_reti),
    .taken_vec(taken_vec), .taken_cnt(taken_cnt)
  );

  task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic idle(int n, logic exp);
    repeat (n) @(negedge clk);
    chk("request", 16'(exp), 16'(irq_request));
  endtask

  task automatic wait_req(logic [15:0] v);
    int k = 0;
    n0 = taken_cnt;
    while (irq_request !== 1'b1 && k < 10) begin
      @(negedge clk);
      k++;
    end
    chk("request", 16'h0001, 16'(irq_request));
    chk("vector", v, irq_vector);
  endtask

  task automatic serve(logic [15:0] v, logic [3:0] clr, logic [1:0] lvl);
    int k = 0;
    while (taken_cnt == n0 && k < 10) begin
      @(negedge clk);
      k++;
    end
    chk("taken vector", v, taken_vec);
    chk("flag clear", 16'(clr), 16'(hw_flag_clear));
    chk("level", 16'(lvl), 16'(service_level));
    @(negedge clk);
    chk("clear pulse", 16'h0000, 16'(hw_flag_clear));
  endtask

  task automatic do_reti(logic [1:0] lvl);
    reti_go <= 1'b1;
    @(negedge clk);
    reti_go <= 1'b0;
    repeat (2) @(negedge clk);
    chk("level after return", 16'(lvl), 16'(service_level));
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Whole run is about 330 cycles; sixty times that means a hang
  initial begin
    #500000;
    num_errors++;
    end_sim();
  end

  initial begin
    f[0] = 1'b1;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    idle(3, 1'b1);
    chk("reset vector", 16'h0000, irq_vector);
    chk("reset level", 16'h0000, 16'(service_level));
    f = '0;
    ip = 7'h00;
    auto_ack <= 1'b1;
    n0 = taken_cnt;
    serve(16'h0000, 4'h0, 2'b00);
    idle(1, 1'b0);
    $display("test reset done");
    for (int i = 0; i < 35; i++) begin
      lag <= 2'(i % 3);
      f[i] = 1'b1;
      wait_req(16'h0003 + 16'(rk[i]) * 16'h0008);
      serve(16'h0003 + 16'(rk[i]) * 16'h0008,
            (rk[i] < 4) ? 4'(1 << rk[i]) : 4'h0, 2'b01);
      f[i] = 1'b0;
      do_reti(2'b00);
    end
    $display("test table done");
    ien = 8'h7F;
    f[0] = 1'b1;
    idle(6, 1'b0);
    ien = 8'hFE;
    idle(6, 1'b0);
    ip = 7'h01;
    ien = 8'hFF;
    wait_req(16'h0003);
    serve(16'h0003, 4'h1, 2'b10);
    f[0] = 1'b0;
    do_reti(2'b00);
    ip = 7'h00;
    $display("test masks done");
    auto_ack <= 1'b0;
    f[0] = 1'b1;
    f[33] = 1'b1;
    pb = 8'h20;
    wait_req(16'h00A3);
    ce = 1'b0;
    pb = 8'h00;
    idle(3, 1'b1);
    chk("frozen vector", 16'h00A3, irq_vector);
    ce = 1'b1;
    idle(2, 1'b1);
    chk("tie vector", 16'h0003, irq_vector);
    f[0] = 1'b0;
    f[33] = 1'b0;
    idle(3, 1'b0);
    $display("test ranking done");
    auto_ack <= 1'b1;
    f[6] = 1'b1;
    wait_req(16'h002B);
    serve(16'h002B, 4'h0, 2'b01);
    ip = 7'h01;
    f[0] = 1'b1;
    wait_req(16'h0003);
    serve(16'h0003, 4'h1, 2'b11);
    f[0] = 1'b0;
    ip = 7'h09;
    f[3] = 1'b1;
    idle(6, 1'b0);
    do_reti(2'b01);
    wait_req(16'h001B);
    serve(16'h001B, 4'h8, 2'b11);
    f[3] = 1'b0;
    f[6] = 1'b0;
    do_reti(2'b01);
    do_reti(2'b00);
    idle(3, 1'b0);
    $display("test nesting done");
    end_sim();
  end
endmodule
